// ===== testbench/alu_slice_sva.sv
/*
  Bus timing and read-width checks for the execute slice.
  Assumes binding to alu_slice, one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module alu_slice_sva (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  logic [7:0] rd_addr_reg;
  wire logic ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire logic [7:0] rd_addr_next = ar_take ? S_AXI_ARADDR_I : rd_addr_reg;
  wire logic rv = S_AXI_RVALID_O;
  always_ff @(posedge CLK_SYS_I) begin
    rd_addr_reg <= rd_addr_next;
  end
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  sequence s_write_taken;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
  endsequence
  sequence s_write_answer;
    !S_AXI_BVALID_O ##1 S_AXI_BVALID_O;
  endsequence
  a_write_answer: assert property (s_write_taken |=> s_write_answer)
    else $error("Write response late.");
  a_write_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O
    && $stable(S_AXI_BRESP_O)) else $error("Write response dropped.");
  a_read_answer: assert property (ar_take |=> rv) else $error("Read data late.");
  a_read_hold: assert property (rv && !S_AXI_RREADY_I |=> rv && $stable(S_AXI_RDATA_O))
    else $error("Read data dropped.");
  a_read_refuse: assert property (rv |-> !S_AXI_ARREADY_O) else $error("Read taken early.");
  a_acc_width: assert property (rv && rd_addr_reg == alu_pkg::OFF_ACC |->
    S_AXI_RDATA_O[31:8] == 24'h0) else $error("Accumulator wider than a byte.");
  a_flag_width: assert property (rv && rd_addr_reg == alu_pkg::OFF_STATUS |->
    S_AXI_RDATA_O[31:3] == 29'h0) else $error("Stray status bits.");
  a_pc_width: assert property (rv && rd_addr_reg == alu_pkg::OFF_PC |->
    S_AXI_RDATA_O[31:12] == 20'h0) else $error("Counter wider than 12 bits.");
  a_page_width: assert property (rv && rd_addr_reg == alu_pkg::OFF_PAGE |->
    S_AXI_RDATA_O[31:4] == 28'h0) else $error("Page buffer wider than 4 bits.");
endmodule
bind alu_slice alu_slice_sva u_alu_slice_sva (.CLK_SYS_I, .RST_I, .S_AXI_AWVALID_I,
  .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O,
  .S_AXI_BREADY_I, .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O,
  .S_AXI_RVALID_O, .S_AXI_RREADY_I);

// ===== testbench/tb_alu_slice.sv
/*
  Self-checking bench for the execute slice, driving its register bus.
  Assumes alu_slice with an AXI4-Lite slave and a 40 MHz clock.
*/
`timescale 1ns/1ps
module tb_alu_slice;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd_val;
  int err_total = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  alu_slice u_alu_slice (.CLK_SYS_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready));
  // ------------------------------------------------------------------
  // Bus and checking tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Each channel is released at the edge that takes it, so the slave may take them apart.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_val = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  // Status reads as {z, half carry, carry}.
  function automatic logic [2:0] sub_st(input logic [7:0] r, input logic [7:0] a);
    return {r == a, r[3:0] >= a[3:0], r >= a};
  endfunction
  task automatic op_chk(input logic [3:0] op, input logic dst, input logic [7:0] acc, rg, imm,
    input logic [2:0] st, input logic [7:0] e_acc, e_reg, input logic [2:0] e_st);
    wr(alu_pkg::OFF_ACC, {24'h0, acc});
    wr(alu_pkg::OFF_REG, {24'h0, rg});
    wr(alu_pkg::OFF_OPERAND, {24'h0, imm});
    wr(alu_pkg::OFF_STATUS, {29'h0, st});
    wr(alu_pkg::OFF_CMD, {27'h0, dst, op});
    rd(alu_pkg::OFF_ACC);
    chk(rd_val, {24'h0, e_acc});
    rd(alu_pkg::OFF_REG);
    chk(rd_val, {24'h0, e_reg});
    rd(alu_pkg::OFF_STATUS);
    chk(rd_val, {29'h0, e_st});
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_bus();
    rd(alu_pkg::OFF_PC);
    chk(rd_val, 32'h0);
    rd(alu_pkg::OFF_ACC);
    chk(rd_val, 32'h0);
    chk({30'h0, rsp}, {30'h0, alu_pkg::RESP_OKAY});
    rd(8'h20);
    chk({30'h0, rsp}, {30'h0, alu_pkg::RESP_SLVERR});
    wr(8'h24, 32'h1);
    chk({30'h0, rsp}, {30'h0, alu_pkg::RESP_SLVERR});
    // A write with its low byte lane off is answered but changes nothing.
    wstrb <= 4'h0;
    wr(alu_pkg::OFF_ACC, 32'hFF);
    chk({30'h0, rsp}, {30'h0, alu_pkg::RESP_OKAY});
    wstrb <= 4'hF;
    rd(alu_pkg::OFF_ACC);
    chk(rd_val, 32'h0);
  endtask
  task automatic t_sub();
    logic [7:0] r [4] = '{8'h05, 8'h03, 8'h10, 8'h7E};
    logic [7:0] a [4] = '{8'h03, 8'h05, 8'h01, 8'h7E};
    logic [7:0] df;
    for (int i = 0; i < 4; i++) begin
      df = r[i] - a[i];
      op_chk(alu_pkg::OP_SUB_ACC_FROM_REG, i[0], a[i], r[i], 8'h00, {3{i[1]}},
        i[0] ? a[i] : df, i[0] ? df : r[i], sub_st(r[i], a[i]));
      op_chk(alu_pkg::OP_SUB_ACC_FROM_IMM, 1'b0, a[i], 8'h00, r[i], {3{i[0]}},
        df, 8'h00, sub_st(r[i], a[i]));
    end
  endtask
  task automatic t_swap_xor();
    op_chk(alu_pkg::OP_NIBBLE_SWAP_REG, 1'b0, 8'h3C, 8'hA5, 8'h0, 3'h5,
      8'h5A, 8'hA5, 3'h5);
    op_chk(alu_pkg::OP_NIBBLE_SWAP_REG, 1'b1, 8'h3C, 8'hA5, 8'h0, 3'h2,
      8'h3C, 8'h5A, 3'h2);
    op_chk(alu_pkg::OP_XOR_ACC_REG, 1'b0, 8'h3C, 8'hA5, 8'h0, 3'h7, 8'h99, 8'hA5, 3'h3);
    op_chk(alu_pkg::OP_XOR_ACC_REG, 1'b1, 8'h66, 8'h66, 8'h0, 3'h3, 8'h66, 8'h00, 3'h7);
    op_chk(alu_pkg::OP_XOR_IMM_ACC, 1'b0, 8'hF0, 8'h00, 8'hF0, 3'h0, 8'h00, 8'h00, 3'h4);
    op_chk(alu_pkg::OP_XOR_IMM_ACC, 1'b0, 8'hF0, 8'h00, 8'h0F, 3'h7, 8'hFF, 8'h00, 3'h3);
  endtask
  task automatic t_table();
    wr(alu_pkg::OFF_OPERAND, 32'h2);
    wr(alu_pkg::OFF_CMD, {28'h0, alu_pkg::OP_PAGE_SELECT});
    rd(alu_pkg::OFF_PAGE);
    chk(rd_val, 32'h8);
    wr(alu_pkg::OFF_PC, 32'h3F0);
    op_chk(alu_pkg::OP_TABLE_JUMP, 1'b0, 8'h20, 8'h11, 8'h0, 3'h4, 8'h20, 8'h11, 3'h1);
    rd(alu_pkg::OFF_PC);
    chk(rd_val, 32'hB10);
    wr(alu_pkg::OFF_PC, 32'h0FF);
    op_chk(alu_pkg::OP_TABLE_JUMP, 1'b0, 8'h01, 8'h11, 8'h0, 3'h0, 8'h01, 8'h11, 3'h7);
    rd(alu_pkg::OFF_PC);
    chk(rd_val, 32'h800);
  endtask
  task automatic t_ret();
    wr(alu_pkg::OFF_STACK, 32'h5A5);
    op_chk(alu_pkg::OP_RETURN_WITH_IMM, 1'b0, 8'h0, 8'h11, 8'h77, 3'h2,
      8'h77, 8'h11, 3'h2);
    rd(alu_pkg::OFF_PC);
    chk(rd_val, 32'h5A5);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_bus();
    t_sub();
    t_swap_xor();
    t_table();
    t_ret();
    close_out();
  end
  // The full run needs about 400 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    close_out();
  end
endmodule

// ===== verilog/alu_pkg.sv
/*
  Shared constants and types for the subtract, swap, exclusive-OR and table-lookup
  execute slice and its register bus.
  Assumes an AXI4-Lite master with 32-bit data and one clock.
*/
package alu_pkg;
  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_OPERAND = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_REG = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PC = 8'h14;
  localparam logic [7:0] OFF_PAGE = 8'h18;
  localparam logic [7:0] OFF_STACK = 8'h1C;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 4;
  localparam int ST_C_BIT = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int PAGE_LSB = 2;

  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_SUB_ACC_FROM_REG = 4'h1,
    OP_SUB_ACC_FROM_IMM = 4'h2,
    OP_NIBBLE_SWAP_REG = 4'h3,
    OP_TABLE_JUMP = 4'h4,
    OP_XOR_ACC_REG = 4'h5,
    OP_XOR_IMM_ACC = 4'h6,
    OP_PAGE_SELECT = 4'h7,
    OP_RETURN_WITH_IMM = 4'h8
  } op_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic z;
  } flags_t;

  typedef struct packed {
    logic [7:0] value;
    flags_t flags;
  } alu_result_t;
endpackage

// ===== verilog/alu_slice.sv
/*
  Execute slice: subtract, nibble swap, exclusive-OR, table lookup, page
  select and return with immediate, driven over an AXI4-Lite slave.
  Assumes one clock, synchronous active-high reset, one write and one read
  outstanding at a time.
*/
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Register minus accumulator goes to dest (0 accumulator, 1 register) and sets every flag.
// RULE2: Immediate minus accumulator goes to the accumulator in one cycle and sets every flag.
// RULE3: Nibble swap exchanges the halves of the register, steers by dest, and changes no flag.
// RULE4: Table jump adds the accumulator to PC bits 7:0, keeps 9:8 and takes 11:10 from page 3:2.
// RULE5: Register XOR accumulator steers by dest and updates only Z.
// RULE6: Immediate XOR accumulator goes to the accumulator and updates only Z.
// RULE7: Page select loads page buffer bits 3:2 from a 2-bit immediate.
// RULE8: Return with immediate loads the accumulator from the immediate and PC from the stack top.
// RULE9: Carry and half-carry are set when no borrow occurs; zero is set for a zero result.
module alu_slice (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [7:0] accumulator_reg;
  logic [7:0] file_reg;
  logic [7:0] operand_reg;
  logic [11:0] pc_reg;
  logic [11:0] stack_top_reg;
  logic [3:0] pc_page_buffer_reg;
  alu_pkg::flags_t flags_reg;
  logic [7:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Subtraction: a - b with carry meaning no borrow.
  function automatic alu_pkg::alu_result_t sub8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    alu_pkg::alu_result_t r;
    full = {1'b0, a} + {1'b0, ~b} + 9'h001;
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
    r.value = full[7:0];
    r.flags.c = full[8]; // RULE9
    r.flags.dc = low[4]; // RULE9
    r.flags.z = (full[7:0] == 8'h00); // RULE9
    return r;
  endfunction

  // Addition used by the table jump.
  function automatic alu_pkg::alu_result_t add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    alu_pkg::alu_result_t r;
    full = {1'b0, a} + {1'b0, b};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    r.value = full[7:0];
    r.flags.c = full[8];
    r.flags.dc = low[4];
    r.flags.z = (full[7:0] == 8'h00);
    return r;
  endfunction

  // ------------------------------------------------------------------
  // Write channel
  // ------------------------------------------------------------------
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [7:0] wr_addr = aw_addr_reg;
  wire wr_cmd = do_write && (wr_addr == alu_pkg::OFF_CMD);
  wire wr_known = (wr_addr == alu_pkg::OFF_CMD) || (wr_addr == alu_pkg::OFF_OPERAND)
    || (wr_addr == alu_pkg::OFF_ACC) || (wr_addr == alu_pkg::OFF_REG)
    || (wr_addr == alu_pkg::OFF_STATUS) || (wr_addr == alu_pkg::OFF_PC)
    || (wr_addr == alu_pkg::OFF_PAGE) || (wr_addr == alu_pkg::OFF_STACK);
  wire [3:0] cmd_op = w_data_reg[alu_pkg::CMD_OP_LSB +: 4];
  wire cmd_dest = w_data_reg[alu_pkg::CMD_DEST_BIT];
  logic wstrb0_reg;
  wire byte0_ok = do_write && wr_known && wstrb0_reg;

  assign S_AXI_AWREADY_O = !aw_held_reg && !bvalid_reg;
  assign S_AXI_WREADY_O = !w_held_reg && !bvalid_reg;
  assign S_AXI_BVALID_O = bvalid_reg;
  assign S_AXI_BRESP_O = bresp_reg;

  // ------------------------------------------------------------------
  // Execute
  // ------------------------------------------------------------------
  wire exec = wr_cmd && wstrb0_reg;
  wire [7:0] imm = operand_reg;
  wire alu_pkg::alu_result_t sub_reg_res = sub8(file_reg, accumulator_reg);
  wire alu_pkg::alu_result_t sub_imm_res = sub8(imm, accumulator_reg);
  wire alu_pkg::alu_result_t jump_res = add8(pc_reg[7:0], accumulator_reg);
  wire [7:0] swap_res = {file_reg[3:0], file_reg[7:4]};
  wire [7:0] xor_reg_res = accumulator_reg ^ file_reg;
  wire [7:0] xor_imm_res = accumulator_reg ^ imm;

  logic [7:0] acc_next;
  logic [7:0] file_next;
  logic [11:0] pc_next;
  logic [3:0] page_next;
  alu_pkg::flags_t flags_next;

  always_comb begin
    acc_next = accumulator_reg;
    file_next = file_reg;
    pc_next = pc_reg;
    page_next = pc_page_buffer_reg;
    flags_next = flags_reg;
    if (exec) begin
      case (alu_pkg::op_t'(cmd_op))
        alu_pkg::OP_SUB_ACC_FROM_REG: begin
          if (cmd_dest) file_next = sub_reg_res.value; // RULE1
          else acc_next = sub_reg_res.value; // RULE1
          flags_next = sub_reg_res.flags; // RULE1
        end
        alu_pkg::OP_SUB_ACC_FROM_IMM: begin
          acc_next = sub_imm_res.value; // RULE2
          flags_next = sub_imm_res.flags; // RULE2
        end
        alu_pkg::OP_NIBBLE_SWAP_REG: begin
          if (cmd_dest) file_next = swap_res; // RULE3
          else acc_next = swap_res; // RULE3
        end
        alu_pkg::OP_TABLE_JUMP: begin
          pc_next = {pc_page_buffer_reg[alu_pkg::PAGE_LSB +: 2], pc_reg[9:8],
            jump_res.value}; // RULE4
          flags_next = jump_res.flags; // RULE4
        end
        alu_pkg::OP_XOR_ACC_REG: begin
          if (cmd_dest) file_next = xor_reg_res; // RULE5
          else acc_next = xor_reg_res; // RULE5
          flags_next.z = (xor_reg_res == 8'h00); // RULE5
        end
        alu_pkg::OP_XOR_IMM_ACC: begin
          acc_next = xor_imm_res; // RULE6
          flags_next.z = (xor_imm_res == 8'h00); // RULE6
        end
        alu_pkg::OP_PAGE_SELECT: begin
          page_next[alu_pkg::PAGE_LSB +: 2] = imm[1:0]; // RULE7
        end
        alu_pkg::OP_RETURN_WITH_IMM: begin
          acc_next = imm; // RULE8
          pc_next = stack_top_reg; // RULE8
        end
        default: begin
          acc_next = accumulator_reg;
        end
      endcase
    end else if (byte0_ok) begin
      // Direct loads let software set up operands; only the low byte lane counts.
      case (wr_addr)
        alu_pkg::OFF_ACC: acc_next = w_data_reg[7:0];
        alu_pkg::OFF_REG: file_next = w_data_reg[7:0];
        alu_pkg::OFF_STATUS: flags_next = '{c: w_data_reg[alu_pkg::ST_C_BIT],
          dc: w_data_reg[alu_pkg::ST_DC_BIT], z: w_data_reg[alu_pkg::ST_Z_BIT]};
        alu_pkg::OFF_PAGE: page_next = w_data_reg[3:0];
        default: pc_next = pc_reg;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      accumulator_reg <= alu_pkg::ACC_RST;
      file_reg <= 8'h00;
      operand_reg <= 8'h00;
      pc_reg <= alu_pkg::PC_RST;
      stack_top_reg <= alu_pkg::PC_RST;
      pc_page_buffer_reg <= 4'h0;
      flags_reg <= '0;
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= alu_pkg::RESP_OKAY;
    end else begin
      accumulator_reg <= acc_next;
      file_reg <= file_next;
      pc_reg <= pc_next;
      pc_page_buffer_reg <= page_next;
      flags_reg <= flags_next;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA_I;
        wstrb0_reg <= S_AXI_WSTRB_I[0];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? alu_pkg::RESP_OKAY : alu_pkg::RESP_SLVERR;
        if (wr_addr == alu_pkg::OFF_OPERAND && wstrb0_reg) operand_reg <= w_data_reg[7:0];
        if (wr_addr == alu_pkg::OFF_PC && wstrb0_reg) pc_reg <= w_data_reg[11:0];
        if (wr_addr == alu_pkg::OFF_STACK && wstrb0_reg) stack_top_reg <= w_data_reg[11:0];
      end else if (bvalid_reg && S_AXI_BREADY_I) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read channel
  // ------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    case (S_AXI_ARADDR_I)
      alu_pkg::OFF_OPERAND: rd_mux = {24'h000000, operand_reg};
      alu_pkg::OFF_ACC: rd_mux = {24'h000000, accumulator_reg};
      alu_pkg::OFF_REG: rd_mux = {24'h000000, file_reg};
      alu_pkg::OFF_STATUS: rd_mux = {29'h00000000, flags_reg.z, flags_reg.dc, flags_reg.c};
      alu_pkg::OFF_PC: rd_mux = {20'h00000, pc_reg};
      alu_pkg::OFF_PAGE: rd_mux = {28'h0000000, pc_page_buffer_reg};
      alu_pkg::OFF_STACK: rd_mux = {20'h00000, stack_top_reg};
      alu_pkg::OFF_CMD: rd_mux = 32'h00000000;
      default: begin
        rd_mux = 32'h00000000;
        rd_known = 1'b0;
      end
    endcase
  end

  assign S_AXI_ARREADY_O = !rvalid_reg;
  assign S_AXI_RVALID_O = rvalid_reg;
  assign S_AXI_RDATA_O = rdata_reg;
  assign S_AXI_RRESP_O = rresp_reg;

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= alu_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID_I && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_known ? alu_pkg::RESP_OKAY : alu_pkg::RESP_SLVERR;
    end else if (rvalid_reg && S_AXI_RREADY_I) begin
      rvalid_reg <= 1'b0;
    end
  end
endmodule
